// ### core/sat_aux_tdm_output.sv
// Aux TDM output: register slave, clock select and frame serialiser
`timescale 1ns/100ps
module sat_aux_tdm_output
	import sat_pkg::*;
(
	input  wire logic              REF_CLK,
	input  wire logic              RST,
	input  wire logic [17:0]       AVS_ADDRESS,
	input  wire logic              AVS_READ,
	input  wire logic              AVS_WRITE,
	input  wire logic [31:0]       AVS_WRITEDATA,
	input  wire logic [3:0]        AVS_BYTEENABLE,
	output logic      [31:0]       AVS_READDATA,
	output logic                   AVS_WAITREQUEST,
	input  sat_frame_s             RX_FRAME,
	input  wire logic              RX_VALID,
	output logic                   RX_READY,
	input  wire logic              REC_BIT_CLOCK,
	input  wire logic              REC_FRAME_CLOCK,
	input  wire logic              GEN3_BIT_CLOCK,
	input  wire logic              GEN3_FRAME_CLOCK,
	output logic      [3:0]        SERIAL_DATA_OUTPUT_PIN,
	output logic      [3:0]        OUTPUT_BIT_CLOCK_PIN,
	output logic      [3:0]        OUTPUT_FRAME_CLOCK_PIN
);

	// True when exactly one bit is set
	function automatic logic is_onehot(input logic [3:0] v);
		return (v != 4'h0) && ((v & (v - 4'h1)) == 4'h0);
	endfunction : is_onehot

	// Builds one 32-bit slot of the frame
	function automatic logic [31:0] slot_word(
		input sat_frame_s f,
		input logic [2:0] sl
	);
		logic [31:0] w;
		w = '0;
		unique case (sl)
			// Left sample then padding
			SAT_SL_LAUD: w = {f.l_aud, {SAT_PAD_W{1'b0}}}; // RULE2
			// Left P V U C
			SAT_SL_LAUX: w = {{SAT_AUX_POS{1'b0}}, f.l_aux,
				{SAT_PAD_W{1'b0}}}; // RULE3
			// Compression bit only counts for compressed audio
			SAT_SL_TYPE: w = {{SAT_CMP_POS{1'b0}}, f.compr & f.atype,
				f.atype, {SAT_PAD_W{1'b0}}}; // RULE4 RULE14
			// Empty slots
			SAT_SL_Z0,
			SAT_SL_Z1:   w = '0; // RULE5
			// Right sample then padding
			SAT_SL_RAUD: w = {f.r_aud, {SAT_PAD_W{1'b0}}}; // RULE6
			// Right P V U C
			SAT_SL_RAUX: w = {{SAT_AUX_POS{1'b0}}, f.r_aux,
				{SAT_PAD_W{1'b0}}}; // RULE7
			// Block start marker
			SAT_SL_BLK:  w = {{SAT_BLK_POS{1'b0}}, f.blk,
				{SAT_PAD_W{1'b0}}}; // RULE8
		endcase
		return w;
	endfunction : slot_word

	// Bit to send at frame position c, most significant first
	function automatic logic slot_bit(
		input sat_frame_s f,
		input logic [7:0] c
	);
		logic [31:0] w;
		w = slot_word(f, c[7:5]);
		return w[SAT_POS_MAX - c[4:0]]; // RULE15
	endfunction : slot_bit

	// Register bus state
	sat_ctrl_s   ctrl_q, ctrl_d;     // Control register
	logic        ack_q, ack_d;       // Answer phase of a request
	logic [31:0] rdata_q, rdata_d;   // Read data holding register
	logic [31:0] stat_w;             // Status word

	// Stream state
	sat_state_e  st_q, st_d;         // Serialiser state
	logic [7:0]  cnt_q, cnt_d;       // Bit position in frame
	sat_frame_s  frame_q, frame_d;   // Frame being sent
	logic        bprev_q, bprev_d;   // Previous bit clock level
	logic        lprev_q, lprev_d;   // Previous frame clock level
	logic [3:0]  sdata_q, sdata_d;   // Data pins
	logic [3:0]  bck_q, bck_d;       // Bit clock pins
	logic [3:0]  lrk_q, lrk_d;       // Frame clock pins

	// Synchronised clocks and selection
	logic        rec_b, rec_l;       // Recovered, filtered
	logic        gen_b, gen_l;       // Generator, filtered
	logic        src_b, src_l;       // Selected source
	logic        sel_ok;             // Port field is one-hot
	logic        bfall, lrise;       // Source edges
	logic        load;               // Frame start

	// Buffer wires
	sat_frame_s  buf_data;           // Head of buffer
	logic        buf_valid;          // Buffer holds a frame
	logic        buf_pop;            // Serialiser takes a frame

	// Input synchronisers
	sat_sync3 u_sync_rb (.clk(REF_CLK), .rst(RST),
		.din(REC_BIT_CLOCK), .dout(rec_b));
	sat_sync3 u_sync_rl (.clk(REF_CLK), .rst(RST),
		.din(REC_FRAME_CLOCK), .dout(rec_l));
	sat_sync3 u_sync_gb (.clk(REF_CLK), .rst(RST),
		.din(GEN3_BIT_CLOCK), .dout(gen_b));
	sat_sync3 u_sync_gl (.clk(REF_CLK), .rst(RST),
		.din(GEN3_FRAME_CLOCK), .dout(gen_l));

	// Frame buffer; a stall by the serialiser stalls the receiver
	sat_buf2 u_buf (
		.clk       (REF_CLK),
		.rst       (RST),
		.in_data   (RX_FRAME),
		.in_valid  (RX_VALID),
		.in_ready  (RX_READY),
		.out_data  (buf_data),
		.out_ready (buf_pop),
		.out_valid (buf_valid)
	);

	// Status: running, buffer state and current slot
	assign stat_w = {24'h000000, cnt_q[7:5], 2'h0, ~RX_READY,
		buf_valid, (st_q == ST_RUN)};

	// Slave answers on the second cycle of each request
	assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_q;
	assign AVS_READDATA    = rdata_q;

	// Register bus next state
	always_comb begin
		ctrl_d  = ctrl_q;
		rdata_d = rdata_q;
		ack_d   = 1'b0;
		if ((AVS_READ | AVS_WRITE) & ~ack_q) begin
			ack_d = 1'b1;
			if (AVS_READ) begin
				// Unmapped reads return zero
				if (AVS_ADDRESS == SAT_CTRL_ADDR)
					rdata_d = {16'h0000, ctrl_q};
				else if (AVS_ADDRESS == SAT_STAT_ADDR)
					rdata_d = stat_w;
				else
					rdata_d = '0;
			end
		end
		// A write lands at the edge where waitrequest is seen low
		if (AVS_WRITE & ack_q & (AVS_ADDRESS == SAT_CTRL_ADDR)) begin
			// Byte lanes 0 and 1 hold the control word
			if (AVS_BYTEENABLE[0])
				ctrl_d[7:0] = AVS_WRITEDATA[7:0];
			if (AVS_BYTEENABLE[1])
				ctrl_d[15:8] = AVS_WRITEDATA[15:8];
		end
	end

	// Register bus flops
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			ctrl_q  <= SAT_CTRL_RST;
			ack_q   <= 1'b0;
			rdata_q <= '0;
		end else begin
			ctrl_q  <= ctrl_d;
			ack_q   <= ack_d;
			rdata_q <= rdata_d;
		end
	end

	// Clock source select and edge detect
	always_comb begin
		sel_ok  = is_onehot(ctrl_q.port_sel); // RULE9
		src_b   = ctrl_q.clk_src ? gen_b : rec_b; // RULE11 RULE12
		src_l   = ctrl_q.clk_src ? gen_l : rec_l; // RULE11 RULE12
		bprev_d = src_b;
		lprev_d = src_l;
		bfall   = bprev_q & ~src_b;
		lrise   = ~lprev_q & src_l;
	end

	// Serialiser next state
	always_comb begin
		st_d    = st_q;
		cnt_d   = cnt_q;
		frame_d = frame_q;
		load    = 1'b0;
		unique case (st_q)
			// Stream disabled
			ST_OFF: begin
				if (sel_ok) st_d = ST_SYNC;
			end
			// Wait for the first frame edge
			ST_SYNC: begin
				if (!sel_ok) st_d = ST_OFF;
				else if (lrise) begin
					st_d = ST_RUN;
					load = 1'b1;
				end
			end
			// Shift frame bits on bit clock falls
			ST_RUN: begin
				if (!sel_ok) st_d = ST_OFF; // RULE9
				else if (lrise) load = 1'b1;
				else if (bfall) cnt_d = cnt_q + 8'h01;
			end
			// Illegal code recovers to off
			default: st_d = ST_OFF;
		endcase
		// New frame; an empty buffer sends a silent frame
		if (load) begin
			cnt_d   = 8'h00;
			frame_d = buf_valid ? buf_data : '0;
		end
		buf_pop = load & buf_valid;
	end

	// Pin drive for the selected port only
	always_comb begin
		sdata_d = '0;
		bck_d   = '0;
		lrk_d   = '0;
		if (st_d == ST_RUN)
			sdata_d = ctrl_q.port_sel &
				{4{slot_bit(frame_d, cnt_d)}}; // RULE1
		// Clocks driven as master of the selected port
		if (sel_ok) begin
			bck_d = ctrl_q.port_sel & {4{src_b}}; // RULE10 RULE11
			lrk_d = ctrl_q.port_sel & {4{src_l}}; // RULE10 RULE12
		end
	end

	// Serialiser and pin flops
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			st_q    <= ST_OFF;
			cnt_q   <= 8'h00;
			frame_q <= '0;
			bprev_q <= 1'b0;
			lprev_q <= 1'b0;
			sdata_q <= '0;
			bck_q   <= '0;
			lrk_q   <= '0;
		end else begin
			st_q    <= st_d;
			cnt_q   <= cnt_d;
			frame_q <= frame_d;
			bprev_q <= bprev_d;
			lprev_q <= lprev_d;
			sdata_q <= sdata_d;
			bck_q   <= bck_d;
			lrk_q   <= lrk_d;
		end
	end

	assign SERIAL_DATA_OUTPUT_PIN = sdata_q;
	assign OUTPUT_BIT_CLOCK_PIN   = bck_q;
	assign OUTPUT_FRAME_CLOCK_PIN = lrk_q;

	// Checks on the serial stream
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RST);

	logic       run_w;   // Stream running
	logic       bit_w;   // Bit on the wire
	logic [2:0] slot_w;  // Current slot
	logic [4:0] pos_w;   // Position in slot
	assign run_w  = (st_q == ST_RUN);
	assign bit_w  = |sdata_q;
	assign slot_w = cnt_q[7:5];
	assign pos_w  = cnt_q[4:0];

	property p_left_aud;
		run_w && slot_w == SAT_SL_LAUD && pos_w < SAT_AUD_W |->
			bit_w == frame_q.l_aud[SAT_AUD_W - 1 - pos_w];
	endproperty
	a_left_aud: assert property (p_left_aud) // RULE2
		else $error("left sample bit wrong");
	property p_pad;
		run_w && pos_w >= SAT_AUD_W |-> !bit_w;
	endproperty
	a_pad: assert property (p_pad) // RULE6
		else $error("slot tail not zero");
	property p_left_aux;
		run_w && slot_w == SAT_SL_LAUX && pos_w >= SAT_AUX_POS &&
			pos_w < SAT_AUD_W |->
			bit_w == frame_q.l_aux[SAT_AUD_W - 1 - pos_w];
	endproperty
	a_left_aux: assert property (p_left_aux) // RULE3
		else $error("left aux bit wrong");
	property p_type;
		run_w && slot_w == SAT_SL_TYPE && pos_w == SAT_CMP_POS |->
			bit_w == (frame_q.compr & frame_q.atype);
	endproperty
	a_type: assert property (p_type) // RULE4
		else $error("compression bit wrong");
	property p_empty;
		run_w && (slot_w == SAT_SL_Z0 || slot_w == SAT_SL_Z1) |-> !bit_w;
	endproperty
	a_empty: assert property (p_empty) // RULE5
		else $error("empty slot not zero");
	property p_right_aux;
		run_w && slot_w == SAT_SL_RAUX && pos_w >= SAT_AUX_POS &&
			pos_w < SAT_AUD_W |->
			bit_w == frame_q.r_aux[SAT_AUD_W - 1 - pos_w];
	endproperty
	a_right_aux: assert property (p_right_aux) // RULE7
		else $error("right aux bit wrong");
	property p_blk;
		run_w && slot_w == SAT_SL_BLK && pos_w == SAT_BLK_POS |->
			bit_w == frame_q.blk;
	endproperty
	a_blk: assert property (p_blk) // RULE8
		else $error("block start bit wrong");
	property p_off;
		!sel_ok |=> sdata_q == 4'h0 && bck_q == 4'h0 && lrk_q == 4'h0;
	endproperty
	a_off: assert property (p_off) // RULE9
		else $error("pins driven while disabled");
	property p_route;
		##1 (sdata_q & ~$past(ctrl_q.port_sel)) == 4'h0;
	endproperty
	a_route: assert property (p_route) // RULE1
		else $error("data on unselected port");
	property p_clk_src;
		sel_ok && ctrl_q.clk_src |=>
			bck_q == ($past(ctrl_q.port_sel) & {4{$past(gen_b)}});
	endproperty
	a_clk_src: assert property (p_clk_src) // RULE12
		else $error("generator clock not routed");

	c_run: cover property (st_q == ST_SYNC ##1 run_w);
	c_empty_load: cover property (run_w && load && !buf_valid);
	c_gen_run: cover property (run_w && ctrl_q.clk_src);

endmodule : sat_aux_tdm_output

// ### core/sat_buf2.sv
// Two-entry frame buffer with valid and ready on both sides
`timescale 1ns/100ps
module sat_buf2
	import sat_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst,
	input  sat_frame_s in_data,
	input  wire logic in_valid,
	output logic      in_ready,
	output sat_frame_s out_data,
	input  wire logic out_ready,
	output logic      out_valid
);
	sat_frame_s  e0_q, e0_d; // Head entry
	sat_frame_s  e1_q, e1_d; // Second entry
	logic [1:0]  n_q, n_d;   // Entries held
	logic        push, pop;

	assign in_ready  = (n_q != 2'h2);
	assign out_valid = (n_q != 2'h0);
	assign out_data  = e0_q;

	// Next contents on push and pop
	always_comb begin
		push = in_valid & in_ready;
		pop  = out_ready & out_valid;
		e0_d = e0_q;
		e1_d = e1_q;
		n_d  = n_q;
		if (pop) begin
			e0_d = e1_q;
			n_d  = n_q - 2'h1;
		end
		if (push) begin
			// New word lands behind whatever remains
			if (n_d == 2'h0) e0_d = in_data;
			else e1_d = in_data;
			n_d = n_d + 2'h1;
		end
	end

	// Register stage
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			e0_q <= '0;
			e1_q <= '0;
			n_q  <= 2'h0;
		end else begin
			e0_q <= e0_d;
			e1_q <= e1_d;
			n_q  <= n_d;
		end
	end
endmodule : sat_buf2

// ### core/sat_pkg.sv
// Shared constants, types and register map for the aux TDM output block
//
// Contract
// (RULE1) Selected port carries eight-slot TDM receiver stream
// (RULE2) Slot 0: left 24-bit sample, eight zeros
// (RULE3) Slot 1: 20 zeros, left P V U C, zeros
// (RULE4) Slot 2: 22 zeros, compression, audio type, zeros
// (RULE5) Slots 3 and 6 are all zeros
// (RULE6) Slot 4: right 24-bit sample, eight zeros
// (RULE7) Slot 5: 20 zeros, right P V U C, zeros
// (RULE8) Slot 7: 23 zeros, block start, zeros
// (RULE9) One-hot port select; zero disables stream
// (RULE10) Configurer puts selected port in master mode
// (RULE11) Clock bit 0: use recovered input clocks
// (RULE12) Clock bit 1: use third generator clocks
// (RULE13) Configurer sets generator reference and source
// (RULE14) Compression bit ignored unless audio compressed
// (RULE15) Each slot shifts most significant bit first
package sat_pkg;

	// Avalon byte address width
	localparam int          SAT_ADDR_W    = 18;
	// Register indices; byte address is four times the index
	localparam logic [17:0] SAT_CTRL_IDX  = 18'h0F608;
	localparam logic [17:0] SAT_STAT_IDX  = 18'h0F609;
	localparam logic [17:0] SAT_CTRL_ADDR = SAT_CTRL_IDX << 2;
	localparam logic [17:0] SAT_STAT_ADDR = SAT_STAT_IDX << 2;
	localparam logic [15:0] SAT_CTRL_RST  = 16'h0000;

	// Frame geometry
	localparam int          SAT_AUD_W   = 24; // Sample width
	localparam int          SAT_PAD_W   = 8;  // Trailing zero bits
	localparam int          SAT_AUX_POS = 20; // Zeros before P V U C
	localparam int          SAT_AUX_W   = 4;  // P V U C
	localparam int          SAT_CMP_POS = 22; // Zeros before type bits
	localparam int          SAT_BLK_POS = 23; // Zeros before block bit
	localparam logic [4:0]  SAT_POS_MAX = 5'h1F; // Last bit of a slot

	// Slot numbers
	localparam logic [2:0]  SAT_SL_LAUD = 3'h0;
	localparam logic [2:0]  SAT_SL_LAUX = 3'h1;
	localparam logic [2:0]  SAT_SL_TYPE = 3'h2;
	localparam logic [2:0]  SAT_SL_Z0   = 3'h3;
	localparam logic [2:0]  SAT_SL_RAUD = 3'h4;
	localparam logic [2:0]  SAT_SL_RAUX = 3'h5;
	localparam logic [2:0]  SAT_SL_Z1   = 3'h6;
	localparam logic [2:0]  SAT_SL_BLK  = 3'h7;

	// Control register layout
	typedef struct packed {
		logic [10:0] rsvd;     // Reserved, read back as written
		logic        clk_src;  // aux_clock_source
		logic [3:0]  port_sel; // aux_port_select
	} sat_ctrl_s;

	// One decoded receiver frame; aux fields are {P,V,U,C}
	typedef struct packed {
		logic [23:0] l_aud;
		logic [3:0]  l_aux;
		logic        compr;
		logic        atype;
		logic [23:0] r_aud;
		logic [3:0]  r_aux;
		logic        blk;
	} sat_frame_s;

	// Stream states
	typedef enum logic [2:0] {
		ST_OFF  = 3'b001,
		ST_SYNC = 3'b010,
		ST_RUN  = 3'b100
	} sat_state_e;

endpackage : sat_pkg

// ### core/sat_sync3.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module sat_sync3 (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic din,
	output logic      dout
);
	logic s1_q, s2_q, s3_q; // Synchroniser chain
	logic out_d;            // Filtered next level

	// Change is accepted only when stages two and three agree
	always_comb begin
		out_d = (s2_q == s3_q) ? s3_q : dout;
	end

	// Chain and filtered level
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			dout <= 1'b0;
		end else begin
			s1_q <= din;
			s2_q <= s1_q;
			s3_q <= s2_q;
			dout <= out_d;
		end
	end
endmodule : sat_sync3

// ### test/sat_tdm_sink.sv
// Downstream TDM receiver model that collects one frame per frame clock
`timescale 1ns/100ps
module sat_tdm_sink (
	input  wire logic         bclk,
	input  wire logic         fclk,
	input  wire logic         sdata,
	output logic      [255:0] last_frame,
	output int                frame_cnt
);
	logic [255:0] sh_q;   // Shift register, first bit ends at the top
	int           pos;    // Bits seen since the frame start
	logic         fclk_q; // Frame clock level at the previous bit

	// Start idle so a partial frame is never reported
	initial begin
		sh_q = '0;
		pos = 999;
		fclk_q = 1'b1;
		last_frame = '0;
		frame_cnt = 0;
	end

	// Sample on the bit clock rise, half a bit after the device moved data
	always @(posedge bclk) begin
		if (fclk && !fclk_q) begin // Frame clock rise marks slot 0 MSB
			pos = 0;
		end
		sh_q = {sh_q[254:0], sdata}; // Most significant bit first
		pos++;
		if (pos == 256) begin // Eight slots of 32 bits complete
			last_frame = sh_q;
			frame_cnt++;
		end
		fclk_q = fclk;
	end
endmodule : sat_tdm_sink

// ### test/tb.sv
// Self-checking bench for the aux TDM output block
`timescale 1ns/100ps
module tb
	import sat_pkg::*;
;
	logic             REF_CLK;          // System clock
	logic             RST;              // Async reset
	logic [17:0]      AVS_ADDRESS;      // Register bus address
	logic             AVS_READ;         // Read request
	logic             AVS_WRITE;        // Write request
	logic [31:0]      AVS_WRITEDATA;    // Write data
	logic [3:0]       AVS_BYTEENABLE;   // Write lanes
	logic [31:0]      AVS_READDATA;     // Read data
	logic             AVS_WAITREQUEST;  // Slave stall
	sat_frame_s       RX_FRAME;         // Decoded frame to the block
	logic             RX_VALID;         // Frame offered
	logic             RX_READY;         // Frame accepted
	logic             REC_BIT_CLOCK;    // Recovered bit clock
	logic             REC_FRAME_CLOCK;  // Recovered frame clock
	logic             GEN3_BIT_CLOCK;   // Generator bit clock
	logic             GEN3_FRAME_CLOCK; // Generator frame clock
	logic [3:0]       SERIAL_DATA_OUTPUT_PIN;
	logic [3:0]       OUTPUT_BIT_CLOCK_PIN;
	logic [3:0]       OUTPUT_FRAME_CLOCK_PIN;
	int               error_cnt;        // Mismatches
	int               num_checks;       // Comparisons made
	sat_frame_s       cur;              // Frame the feeder offers next
	logic             use_gen;          // Clocks come from the generator
	int               sel;              // Port the sink listens to
	logic [10:0]      ck;               // Bit and frame clock divider
	logic [10:0]      ck_n;             // Next divider value
	logic             rdy_s;            // Ready sampled before the edge
	logic [255:0]     last_frame;       // Frame seen by the sink
	int               frame_cnt;        // Frames seen by the sink

	sat_aux_tdm_output uut (
		.REF_CLK(REF_CLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS),
		.AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
		.AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
		.AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
		.RX_FRAME(RX_FRAME), .RX_VALID(RX_VALID), .RX_READY(RX_READY),
		.REC_BIT_CLOCK(REC_BIT_CLOCK), .REC_FRAME_CLOCK(REC_FRAME_CLOCK),
		.GEN3_BIT_CLOCK(GEN3_BIT_CLOCK), .GEN3_FRAME_CLOCK(GEN3_FRAME_CLOCK),
		.SERIAL_DATA_OUTPUT_PIN(SERIAL_DATA_OUTPUT_PIN),
		.OUTPUT_BIT_CLOCK_PIN(OUTPUT_BIT_CLOCK_PIN),
		.OUTPUT_FRAME_CLOCK_PIN(OUTPUT_FRAME_CLOCK_PIN)
	);

	sat_tdm_sink sink (
		.bclk(OUTPUT_BIT_CLOCK_PIN[sel]), .fclk(OUTPUT_FRAME_CLOCK_PIN[sel]),
		.sdata(SERIAL_DATA_OUTPUT_PIN[sel]), .last_frame(last_frame),
		.frame_cnt(frame_cnt)
	);

	// 100 MHz system clock
	initial begin
		REF_CLK = 1'b0;
		forever #5 REF_CLK = ~REF_CLK;
	end

	// Source clocks: eight cycles a bit, 256 bits a frame, one source runs
	always @(posedge REF_CLK) begin
		ck_n = ck + 11'h001;
		ck <= ck_n;
		REC_BIT_CLOCK <= ~use_gen & ck_n[2];
		REC_FRAME_CLOCK <= ~use_gen & ~ck_n[10];
		GEN3_BIT_CLOCK <= use_gen & ck_n[2];
		GEN3_FRAME_CLOCK <= use_gen & ~ck_n[10];
	end

	// Feeder holds a frame until the edge that takes it
	always @(negedge REF_CLK) rdy_s = RX_READY;
	always @(posedge REF_CLK) begin
		if (rdy_s === 1'b1) begin
			RX_FRAME <= cur;
		end
	end

	// Compare and count
	task chk(input logic [255:0] got, input logic [255:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One bus cycle, held until waitrequest is seen low
	task avs(input logic wr, input logic [17:0] a, input logic [31:0] d,
		input logic [3:0] be, output logic [31:0] q);
		@(posedge REF_CLK);
		AVS_ADDRESS <= a;
		AVS_WRITE <= wr;
		AVS_READ <= ~wr;
		AVS_WRITEDATA <= d;
		AVS_BYTEENABLE <= be;
		@(posedge REF_CLK);
		while (AVS_WAITREQUEST !== 1'b0) @(posedge REF_CLK);
		q = AVS_READDATA;
		AVS_WRITE <= 1'b0;
		AVS_READ <= 1'b0;
	endtask : avs

	// Read a register and compare
	task rdc(input logic [17:0] a, input logic [31:0] exp);
		logic [31:0] q;
		avs(1'b0, a, 32'h00000000, 4'hF, q);
		chk(q, exp);
	endtask : rdc

	// All pins quiet for a stretch
	task idle_chk;
		logic [11:0] acc;
		acc = '0;
		repeat (64) begin
			@(negedge REF_CLK);
			acc |= {SERIAL_DATA_OUTPUT_PIN, OUTPUT_BIT_CLOCK_PIN,
				OUTPUT_FRAME_CLOCK_PIN};
		end
		chk(acc, 12'h000);
	endtask : idle_chk

	// Wait for more sink frames under a bound
	task wait_frames(input int k);
		int t;
		int n;
		t = frame_cnt + k;
		n = 0;
		while (frame_cnt < t && n < 2200 * (k + 1)) begin
			@(posedge REF_CLK);
			n++;
		end
		if (frame_cnt < t) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, frame_cnt, t);
		end
	endtask : wait_frames

	// Frame as it should appear on the wire, first bit at the top
	function automatic logic [255:0] exp_frame(input sat_frame_s f);
		return {f.l_aud, 8'h00, 20'h00000, f.l_aux, 8'h00,
			22'h000000, f.compr & f.atype, f.atype, 8'h00, 32'h00000000,
			f.r_aud, 8'h00, 20'h00000, f.r_aux, 8'h00, 32'h00000000,
			23'h000000, f.blk, 8'h00};
	endfunction : exp_frame

	// Print counts and verdict, then stop
	task test_done;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : test_done

	// Watchdog against a hang
	initial begin
		#700000;
		error_cnt++;
		$display("Error at %0t: got %h expected %h", $time, 0, 1);
		test_done;
	end

	// Main sequence
	initial begin
		sat_frame_s  f;
		logic [31:0] q;
		logic [3:0]  m;
		logic [255:0] e;
		RST = 1'b1;
		AVS_ADDRESS = '0;
		AVS_READ = 1'b0;
		AVS_WRITE = 1'b0;
		AVS_WRITEDATA = '0;
		AVS_BYTEENABLE = '0;
		RX_VALID = 1'b0;
		RX_FRAME = '0;
		cur = '0;
		use_gen = 1'b0;
		sel = 0;
		ck = '0;
		error_cnt = 0;
		num_checks = 0;
		repeat (2) @(posedge REF_CLK);
		RST <= 1'b0;
		RX_VALID <= 1'b1;
		// Register reset value, lanes, reserved bits and unmapped places
		rdc(SAT_CTRL_ADDR, 32'h00000000);
		avs(1'b1, SAT_CTRL_ADDR, 32'hFFFFFFFF, 4'hF, q);
		rdc(SAT_CTRL_ADDR, 32'h0000FFFF);
		avs(1'b1, SAT_CTRL_ADDR, 32'h00001200, 4'h2, q);
		rdc(SAT_CTRL_ADDR, 32'h000012FF);
		idle_chk;
		avs(1'b1, 18'h00010, 32'h0000FFFF, 4'hF, q);
		avs(1'b1, SAT_CTRL_ADDR, 32'h00000000, 4'hF, q);
		rdc(18'h00010, 32'h00000000);
		rdc(SAT_CTRL_ADDR, 32'h00000000);
		// Stream off: nothing drains, buffer refuses after two frames
		avs(1'b0, SAT_STAT_ADDR, 32'h00000000, 4'hF, q);
		chk(q[2:0], 3'b110);
		chk(RX_READY, 1'b0);
		idle_chk;
		$display("test registers done");
		// Each port in turn, alternating clock source and type flags
		for (int p = 0; p < 4; p++) begin
			f.l_aud = 24'hC35A01 + 24'(p);
			f.l_aux = 4'h9 ^ 4'(p);
			f.compr = ~p[1];
			f.atype = p[0];
			f.r_aud = 24'h3CA580 ^ 24'(p << 8);
			f.r_aux = 4'h6 ^ 4'(p);
			f.blk = ~p[0];
			cur <= f;
			// Generator routed on odd ports, recovered clocks on even, and port made master by the configurer
			use_gen <= p[0];
			sel = p;
			m = 4'h1 << p;
			avs(1'b1, SAT_CTRL_ADDR, {27'h0, p[0], m}, 4'hF, q);
			wait_frames(5);
			e = exp_frame(f);
			chk(last_frame[255:224], e[255:224]);
			chk(last_frame[223:192], e[223:192]);
			chk(last_frame[191:160], e[191:160]);
			chk(last_frame[159:128], e[159:128]);
			chk(last_frame[127:96], e[127:96]);
			chk(last_frame[95:64], e[95:64]);
			chk(last_frame[63:32], e[63:32]);
			chk(last_frame[31:0], e[31:0]);
			@(negedge REF_CLK);
			chk({SERIAL_DATA_OUTPUT_PIN, OUTPUT_BIT_CLOCK_PIN,
				OUTPUT_FRAME_CLOCK_PIN} & ~{m, m, m}, 12'h000);
			$display("test port %0d done", p);
		end
		test_done;
	end
endmodule : tb
